// >>> design/atm_cell_slave_port.sv
// Pin-level slave end of a cell interface with two master-driven clocks
`timescale 1ns/10ps
`include "atm_cell_map.svh"
module atm_cell_slave_port
    import atm_cell_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_cell_port_strap,
    // Core side, transmit mailbox
    input wire logic i_tx_valid,
    input wire cell_byte_t i_tx_byte,
    output logic o_tx_ready,
    input wire logic i_tx_cell_whole,
    // Core side, receive mailbox, shared serial pins and cell mode
    input wire logic i_rx_room,
    output logic o_rx_valid,
    output cell_byte_t o_rx_byte,
    output logic [`SERIAL_SHARED_W-1:0] o_serial_port_one_in,
    output logic o_cell_mode,
    // Transmit link
    input wire logic i_tx_cell_clock,
    input wire logic i_tx_offer_n,
    output logic [`CELL_BYTE_W-1:0] o_tx_cell_bus,
    output logic o_tx_cell_bus_oe,
    output logic o_tx_cell_first,
    output logic o_tx_cell_ready_flag,
    output logic o_tx_flags_oe,
    // Receive link
    input wire logic i_rx_cell_clock,
    input wire logic i_rx_accept_n,
    input wire logic [`CELL_BYTE_W-1:0] i_rx_cell_bus,
    input wire logic i_rx_cell_first,
    input wire logic [`SLAVE_ADDR_W-1:0] i_rx_slave_select,
    output logic o_rx_space_flag,
    output logic o_rx_space_flag_oe
);

    // Plain synchroniser: stage 0 feeds stage 1 only
    logic [1:0] c_strap_s;
    logic [1:0] c_tx_ack_s;
    logic [1:0] c_rx_req_s;
    logic [`SERIAL_SHARED_W-1:0] c_ser_s0;
    logic [`SERIAL_SHARED_W-1:0] c_ser_s1;
    logic [1:0] t_rst_s;
    logic [1:0] t_strap_s;
    logic [1:0] t_req_s;
    logic [1:0] t_whole_s;
    logic [1:0] r_rst_s;
    logic [1:0] r_strap_s;
    logic [1:0] r_ack_s;
    logic [1:0] r_room_s;
    logic c_tx_req_tog_r, c_tx_req_tog_nxt;
    logic c_rx_ack_tog_r, c_rx_ack_tog_nxt;
    logic t_ack_tog_r, t_ack_tog_nxt;
    logic r_req_tog_r, r_req_tog_nxt;
    cell_byte_t r_hold_r, r_hold_nxt;

    always_ff @(posedge i_clk)
    begin
        c_strap_s <= {c_strap_s[0], i_cell_port_strap};
        c_tx_ack_s <= {c_tx_ack_s[0], t_ack_tog_r};
        c_rx_req_s <= {c_rx_req_s[0], r_req_tog_r};
        c_ser_s0 <= i_rx_slave_select[`SLAVE_ADDR_W-1:`SERIAL_SHARED_LSB];
        c_ser_s1 <= c_ser_s0;
    end

    always_ff @(posedge i_tx_cell_clock)
    begin
        t_rst_s <= {t_rst_s[0], i_resetn};
        t_strap_s <= {t_strap_s[0], i_cell_port_strap};
        t_req_s <= {t_req_s[0], c_tx_req_tog_r};
        t_whole_s <= {t_whole_s[0], i_tx_cell_whole};
    end

    always_ff @(posedge i_rx_cell_clock)
    begin
        r_rst_s <= {r_rst_s[0], i_resetn};
        r_strap_s <= {r_strap_s[0], i_cell_port_strap};
        r_ack_s <= {r_ack_s[0], c_rx_ack_tog_r};
        r_room_s <= {r_room_s[0], i_rx_room};
    end

    // Core domain: mailboxes toward both links, strap and serial pins
    cell_byte_t c_tx_hold_r, c_tx_hold_nxt;
    logic o_tx_ready_nxt, o_rx_valid_nxt, o_cell_mode_nxt;
    cell_byte_t o_rx_byte_nxt;
    logic [`SERIAL_SHARED_W-1:0] o_serial_nxt;

    always_comb
    begin
        c_tx_req_tog_nxt = c_tx_req_tog_r;
        c_tx_hold_nxt = c_tx_hold_r;
        c_rx_ack_tog_nxt = c_rx_ack_tog_r;
        o_rx_byte_nxt = o_rx_byte;
        o_rx_valid_nxt = 1'b0;
        // Hold word stays still until the link hands the toggle back
        if (i_tx_valid && o_tx_ready)
        begin
            c_tx_hold_nxt = i_tx_byte;
            c_tx_req_tog_nxt = ~c_tx_req_tog_r;
        end
        // Receive word is stable in the link register while req differs
        if (c_rx_req_s[1] != c_rx_ack_tog_r)
        begin
            o_rx_byte_nxt = r_hold_r;
            o_rx_valid_nxt = 1'b1;
            c_rx_ack_tog_nxt = c_rx_req_s[1];
        end
        o_tx_ready_nxt = (c_tx_req_tog_nxt == c_tx_ack_s[1]);
        o_cell_mode_nxt = c_strap_s[1];
        // Shared pins belong to the serial port while the strap is low
        o_serial_nxt = c_strap_s[1] ? '0 : c_ser_s1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            c_tx_req_tog_r <= 1'b0;
            c_tx_hold_r <= '0;
            c_rx_ack_tog_r <= 1'b0;
            o_tx_ready <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_byte <= '0;
            o_cell_mode <= 1'b0;
            o_serial_port_one_in <= '0;
        end
        else if (i_ce)
        begin
            c_tx_req_tog_r <= c_tx_req_tog_nxt;
            c_tx_hold_r <= c_tx_hold_nxt;
            c_rx_ack_tog_r <= c_rx_ack_tog_nxt;
            o_tx_ready <= o_tx_ready_nxt;
            o_rx_valid <= o_rx_valid_nxt;
            o_rx_byte <= o_rx_byte_nxt;
            o_cell_mode <= o_cell_mode_nxt;
            o_serial_port_one_in <= o_serial_nxt;
        end
    end

    // Transmit domain: one byte mailbox emptied by the master's enable
    mb_state_t t_mb_r, t_mb_nxt;
    cell_byte_t t_hold_r, t_hold_nxt;
    logic [`CELL_BYTE_W-1:0] t_bus_nxt;
    logic t_first_nxt, t_flag_nxt, t_oe_nxt;
    logic t_send;

    always_comb
    begin
        t_mb_nxt = t_mb_r;
        t_hold_nxt = t_hold_r;
        t_ack_tog_nxt = t_ack_tog_r;
        t_bus_nxt = o_tx_cell_bus;
        t_first_nxt = 1'b0;
        t_send = 1'b0;
        unique case (t_mb_r)
            MB_EMPTY:
            begin
                if (t_req_s[1] != t_ack_tog_r)
                begin
                    t_hold_nxt = c_tx_hold_r;
                    t_mb_nxt = MB_FULL;
                end
            end
            MB_FULL:
            begin
                // Enable seen this edge, byte shows in the next cycle
                if (!i_tx_offer_n && t_strap_s[1])
                begin
                    t_send = 1'b1;
                    t_bus_nxt = t_hold_r.data;
                    t_first_nxt = t_hold_r.first;
                    t_ack_tog_nxt = ~t_ack_tog_r;
                    t_mb_nxt = MB_EMPTY;
                end
            end
        endcase
        t_flag_nxt = t_whole_s[1] && t_strap_s[1];
        t_oe_nxt = t_strap_s[1];
        // Tied-off state: quiet bus, flags low, drivers off
        if (!t_strap_s[1])
        begin
            t_bus_nxt = `TIED_BYTE;
            t_first_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_tx_cell_clock)
    begin
        if (!t_rst_s[1])
        begin
            t_mb_r <= MB_EMPTY;
            t_hold_r <= '0;
            t_ack_tog_r <= 1'b0;
            o_tx_cell_bus <= `TIED_BYTE;
            o_tx_cell_first <= 1'b0;
            o_tx_cell_ready_flag <= 1'b0;
            o_tx_cell_bus_oe <= 1'b0;
            o_tx_flags_oe <= 1'b0;
        end
        else
        begin
            t_mb_r <= t_mb_nxt;
            t_hold_r <= t_hold_nxt;
            t_ack_tog_r <= t_ack_tog_nxt;
            o_tx_cell_bus <= t_bus_nxt;
            o_tx_cell_first <= t_first_nxt;
            o_tx_cell_ready_flag <= t_flag_nxt;
            o_tx_cell_bus_oe <= t_oe_nxt;
            o_tx_flags_oe <= t_oe_nxt;
        end
    end

    // Receive domain: registered enable and address, then capture
    logic r_take_r, r_take_nxt;
    logic r_sel_r, r_sel_nxt;
    logic r_free_r, r_free_nxt;
    logic r_flag_nxt, r_flag_oe_nxt;
    logic r_addr_hit;

    always_comb
    begin
        // Low pins ignored when disabled; upper ones go to the serial port
        r_addr_hit = r_strap_s[1]
            && (i_rx_slave_select == `OWN_SLAVE_ADDR);
        r_sel_nxt = r_addr_hit;
        r_take_nxt = !i_rx_accept_n && r_addr_hit;
        r_hold_nxt = r_hold_r;
        r_req_tog_nxt = r_req_tog_r;
        r_free_nxt = r_free_r || (r_ack_s[1] == r_req_tog_r);
        // Sample one cycle after the enable; a full mailbox drops bytes
        if (r_take_r && r_free_r && r_strap_s[1])
        begin
            r_hold_nxt = '{first: i_rx_cell_first, data: i_rx_cell_bus};
            r_req_tog_nxt = ~r_req_tog_r;
            r_free_nxt = 1'b0;
        end
        r_flag_nxt = r_addr_hit && r_room_s[1] && r_free_nxt;
        r_flag_oe_nxt = r_addr_hit;
    end

    always_ff @(posedge i_rx_cell_clock)
    begin
        if (!r_rst_s[1])
        begin
            r_take_r <= 1'b0;
            r_sel_r <= 1'b0;
            r_free_r <= 1'b1;
            r_req_tog_r <= 1'b0;
            r_hold_r <= '0;
            o_rx_space_flag <= 1'b0;
            o_rx_space_flag_oe <= 1'b0;
        end
        else
        begin
            r_take_r <= r_take_nxt;
            r_sel_r <= r_sel_nxt;
            r_free_r <= r_free_nxt;
            r_req_tog_r <= r_req_tog_nxt;
            r_hold_r <= r_hold_nxt;
            o_rx_space_flag <= r_flag_nxt;
            o_rx_space_flag_oe <= r_flag_oe_nxt;
        end
    end

    // Checks on the transmit link
    sequence s_offer_full;
        !i_tx_offer_n && t_strap_s[1] && t_mb_r == MB_FULL;
    endsequence
    a_tx_next_byte: assert property (
        @(posedge i_tx_cell_clock) disable iff (!t_rst_s[1])
        s_offer_full |=> o_tx_cell_bus == $past(t_hold_r.data))
        else $error("transmit byte not driven after enable");
    a_tx_first_mark: assert property (
        @(posedge i_tx_cell_clock) disable iff (!t_rst_s[1])
        s_offer_full |=> o_tx_cell_first == $past(t_hold_r.first))
        else $error("start marker not with first byte");
    a_tx_first_only: assert property (
        @(posedge i_tx_cell_clock) disable iff (!t_rst_s[1])
        o_tx_cell_first |-> $past(t_send))
        else $error("start marker without a sent byte");
    a_tx_ready_flag: assert property (
        @(posedge i_tx_cell_clock) disable iff (!t_rst_s[1])
        ##1 o_tx_cell_ready_flag == $past(t_whole_s[1] && t_strap_s[1]))
        else $error("transmit ready flag wrong");
    a_tx_tied_off: assert property (
        @(posedge i_tx_cell_clock) disable iff (!t_rst_s[1])
        !t_strap_s[1] |=> !o_tx_cell_bus_oe && !o_tx_cell_first
            && o_tx_cell_bus == `TIED_BYTE && !o_tx_cell_ready_flag)
        else $error("transmit pins not tied off");

    // Checks on the receive link
    sequence s_rx_take;
        !i_rx_accept_n && r_addr_hit ##1 r_free_r && r_strap_s[1];
    endsequence
    a_rx_capture: assert property (
        @(posedge i_rx_cell_clock) disable iff (!r_rst_s[1])
        s_rx_take |=> r_hold_r.data == $past(i_rx_cell_bus)
            && r_hold_r.first == $past(i_rx_cell_first))
        else $error("receive byte not captured");
    a_rx_unselected: assert property (
        @(posedge i_rx_cell_clock) disable iff (!r_rst_s[1])
        !r_sel_r ##1 1'b1 |-> $stable(r_req_tog_r))
        else $error("capture while not addressed");
    a_rx_flag_oe: assert property (
        @(posedge i_rx_cell_clock) disable iff (!r_rst_s[1])
        o_rx_space_flag |-> o_rx_space_flag_oe && $past(r_addr_hit))
        else $error("space flag driven while not addressed");
    a_rx_space_room: assert property (
        @(posedge i_rx_cell_clock) disable iff (!r_rst_s[1])
        o_rx_space_flag |-> $past(r_room_s[1]) && r_free_r)
        else $error("space flag without room");
    a_rx_strap_off: assert property (
        @(posedge i_rx_cell_clock) disable iff (!r_rst_s[1])
        !r_strap_s[1] |=> !o_rx_space_flag_oe && !r_take_r)
        else $error("receive side active while disabled");
    // Check on the shared serial pins
    a_serial_share: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_ce && c_strap_s[1] |=> o_serial_port_one_in == '0)
        else $error("serial pins not released in cell mode");
endmodule

// >>> include/atm_cell_map.svh
// Constants for the cell slave port: widths, address, tie-off values
`ifndef ATM_CELL_MAP_SVH
`define ATM_CELL_MAP_SVH
`define CELL_BYTE_W 8
`define SLAVE_ADDR_W 5
`define OWN_SLAVE_ADDR 5'h01
`define TIED_BYTE 8'h00
`define SERIAL_SHARED_W 3
`define SERIAL_SHARED_LSB 2
`define SYNC_STAGES 2
`endif

// >>> include/atm_cell_pkg.sv
// Types shared by the cell slave port
`include "atm_cell_map.svh"
package atm_cell_pkg;
    // One cell byte together with its start-of-cell marker
    typedef struct packed {
        logic first;
        logic [`CELL_BYTE_W-1:0] data;
    } cell_byte_t;

    // Occupancy of a one-byte mailbox
    typedef enum logic [1:0] {
        MB_EMPTY = 2'b01,
        MB_FULL = 2'b10
    } mb_state_t;
endpackage

// >>> sim/cell_master_model.sv
// Behavioural master controller that drives both link directions
`timescale 1ns/10ps
`include "atm_cell_map.svh"
module cell_master_model
    import atm_cell_pkg::*;
(
    output logic o_tx_cell_clock,
    output logic o_rx_cell_clock,
    output logic o_tx_offer_n,
    output logic o_rx_accept_n,
    output logic [`CELL_BYTE_W-1:0] o_rx_cell_bus,
    output logic o_rx_cell_first,
    output logic [`SLAVE_ADDR_W-1:0] o_rx_slave_select,
    input wire logic [`CELL_BYTE_W-1:0] i_tx_cell_bus,
    input wire logic i_tx_cell_first
);
    // Idle pin levels, then a free-running receive clock, offset in phase
    initial
    begin
        o_tx_cell_clock = 1'b0;
        o_rx_cell_clock = 1'b0;
        o_tx_offer_n = 1'b1;
        o_rx_accept_n = 1'b1;
        o_rx_cell_bus = 8'h00;
        o_rx_cell_first = 1'b0;
        o_rx_slave_select = 5'h00;
        #7;
        forever #15 o_rx_cell_clock = ~o_rx_cell_clock;
    end

    // Master supplies the transmit clock as well; 30 ns period
    always #15 o_tx_cell_clock = ~o_tx_cell_clock;

    // Offer one transmit slot; the byte is seen one edge later
    task automatic pull_byte(output cell_byte_t got);
        @(posedge o_tx_cell_clock);
        #1 o_tx_offer_n = 1'b0;
        @(posedge o_tx_cell_clock);
        #1 o_tx_offer_n = 1'b1;
        got = {i_tx_cell_first, i_tx_cell_bus};
    endtask

    // Address a slave ahead of any receive transfer
    task automatic set_addr(input logic [`SLAVE_ADDR_W-1:0] a);
        @(posedge o_rx_cell_clock);
        #1 o_rx_slave_select = a;
    endtask

    // Enable for one edge, data held through the next, then scrambled
    task automatic push_byte(input cell_byte_t b);
        @(posedge o_rx_cell_clock);
        #1;
        o_rx_accept_n = 1'b0;
        o_rx_cell_bus = b.data;
        o_rx_cell_first = b.first;
        @(posedge o_rx_cell_clock);
        #1 o_rx_accept_n = 1'b1;
        @(posedge o_rx_cell_clock);
        #1;
        o_rx_cell_bus = ~b.data; // Stale bus must not look valid
        o_rx_cell_first = ~b.first;
    endtask
endmodule

// >>> sim/tb_atm_cell_slave_port.sv
// Self-checking bench for the cell slave port
`timescale 1ns/10ps
`include "atm_cell_map.svh"
module tb_atm_cell_slave_port import atm_cell_pkg::*;;
    logic clk;
    logic resetn;
    logic strap;
    logic ce;
    logic tx_valid;
    cell_byte_t tx_byte;
    logic tx_whole;
    logic rx_room;
    logic tx_ready, rx_valid, cell_mode, tx_oe, tx_first, tx_flag, flags_oe;
    logic space_flag, space_oe, txc, rxc, offer_n, accept_n, rfirst;
    cell_byte_t rx_byte;
    cell_byte_t got;
    bit seen;
    logic [2:0] serial_in;
    logic [7:0] tx_bus, tx_wire, rbus;
    logic [4:0] rsel;
    int fails = 0;
    int n_checks = 0;

    // Core clock, 25 ns
    always #12.5 clk = ~clk;
    // Released transmit bus shows the inverse of its last value
    assign tx_wire = tx_oe ? tx_bus : ~tx_bus;

    atm_cell_slave_port dut_u (.i_clk(clk), .i_resetn(resetn), .i_ce(ce),
        .i_cell_port_strap(strap), .i_tx_valid(tx_valid),
        .i_tx_byte(tx_byte), .o_tx_ready(tx_ready),
        .i_tx_cell_whole(tx_whole), .i_rx_room(rx_room),
        .o_rx_valid(rx_valid), .o_rx_byte(rx_byte),
        .o_serial_port_one_in(serial_in), .o_cell_mode(cell_mode),
        .i_tx_cell_clock(txc), .i_tx_offer_n(offer_n),
        .o_tx_cell_bus(tx_bus), .o_tx_cell_bus_oe(tx_oe),
        .o_tx_cell_first(tx_first), .o_tx_cell_ready_flag(tx_flag),
        .o_tx_flags_oe(flags_oe), .i_rx_cell_clock(rxc),
        .i_rx_accept_n(accept_n), .i_rx_cell_bus(rbus),
        .i_rx_cell_first(rfirst), .i_rx_slave_select(rsel),
        .o_rx_space_flag(space_flag), .o_rx_space_flag_oe(space_oe));

    cell_master_model m_u (.o_tx_cell_clock(txc), .o_rx_cell_clock(rxc),
        .o_tx_offer_n(offer_n), .o_rx_accept_n(accept_n),
        .o_rx_cell_bus(rbus), .o_rx_cell_first(rfirst),
        .o_rx_slave_select(rsel), .i_tx_cell_bus(tx_wire),
        .i_tx_cell_first(tx_first));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check_v(input string what, input logic [8:0] exp,
        input logic [8:0] got_v);
        n_checks++;
        if (got_v !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got_v);
        end
    endtask

    // Inputs set after a tick change 1 ns after a core edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Hand one byte to the transmit mailbox once it is free
    task automatic send_core(input cell_byte_t b);
        int k;
        tick(1);
        for (k = 0; k < 60 && tx_ready !== 1'b1; k++)
            tick(1);
        if (tx_ready !== 1'b1)
        begin
            fails++;
            $display("ERROR tx_ready expected 1 seen %b", tx_ready);
            end_of_test();
        end
        tx_valid = 1'b1;
        tx_byte = b;
        tick(1);
        tx_valid = 1'b0;
        repeat (4) @(posedge txc); // Mailbox crossing takes 3 edges
    endtask

    // Watch a bounded span for the one-cycle receive pulse
    task automatic wait_rx();
        seen = 1'b0;
        repeat (30)
        begin
            tick(1);
            if (rx_valid === 1'b1 && !seen)
            begin
                seen = 1'b1;
                got = rx_byte;
            end
        end
    endtask

    task automatic t_reset();
        check_v("reset outs", 9'h000, {tx_ready, rx_valid, tx_oe, space_oe});
        tick(1);
        resetn = 1'b1;
        tick(2);
        check_v("tx_ready", 9'h001, tx_ready);
        repeat (4) @(posedge txc);
    endtask

    task automatic t_tx();
        send_core(9'h1A5);
        m_u.pull_byte(got);
        check_v("tx first byte", 9'h1A5, got);
        @(posedge txc);
        #1 check_v("tx first drop", 9'h000, tx_first);
        send_core(9'h05A);
        m_u.pull_byte(got);
        check_v("tx next byte", 9'h05A, got);
        m_u.pull_byte(got);
        check_v("tx empty offer", 9'h05A, got);
    endtask

    task automatic t_flag();
        tick(1);
        tx_whole = 1'b1;
        repeat (6) @(posedge txc);
        #1 check_v("tx flag set", 9'h003, {flags_oe, tx_flag});
        tick(1);
        tx_whole = 1'b0;
        repeat (6) @(posedge txc);
        #1 check_v("tx flag clr", 9'h002, {flags_oe, tx_flag});
    endtask

    // A frozen core must not take a byte offered while the enable is low
    task automatic t_freeze();
        tick(1);
        ce = 1'b0;
        tx_valid = 1'b1;
        tx_byte = 9'h1FF;
        tick(3);
        tx_valid = 1'b0;
        ce = 1'b1;
        tick(3);
        check_v("frozen offer", 9'h001, {8'h00, tx_ready});
    endtask

    task automatic t_rx();
        tick(1);
        rx_room = 1'b1;
        m_u.set_addr(`OWN_SLAVE_ADDR);
        repeat (6) @(posedge rxc);
        #1 check_v("space flag", 9'h003, {space_oe, space_flag});
        m_u.push_byte(9'h1C3);
        wait_rx();
        check_v("rx first seen", 9'h001, {8'h00, seen});
        check_v("rx first byte", 9'h1C3, got);
        m_u.push_byte(9'h03C);
        wait_rx();
        check_v("rx next seen", 9'h001, {8'h00, seen});
        check_v("rx next byte", 9'h03C, got);
        rx_room = 1'b0;
        repeat (6) @(posedge rxc);
        #1 check_v("space full", 9'h002, {space_oe, space_flag});
        rx_room = 1'b1;
    endtask

    task automatic t_unsel();
        m_u.set_addr(5'h02);
        repeat (6) @(posedge rxc);
        #1 check_v("unselected oe", 9'h000, space_oe);
        m_u.push_byte(9'h111);
        wait_rx();
        check_v("unselected rx", 9'h000, seen);
    endtask

    task automatic t_strap();
        tick(1);
        strap = 1'b0;
        tx_whole = 1'b1;
        m_u.set_addr(5'h14);
        repeat (8) @(posedge rxc);
        tick(4);
        check_v("tied pins", 9'h000, {tx_oe, tx_first, tx_flag, flags_oe,
            space_flag, space_oe, cell_mode});
        check_v("tied bus", 9'h000, tx_bus);
        check_v("serial pins", 9'h005, serial_in);
        m_u.set_addr(`OWN_SLAVE_ADDR);
        m_u.push_byte(9'h1EE);
        wait_rx();
        check_v("tied rx", 9'h000, seen);
        strap = 1'b1;
        m_u.set_addr(5'h14);
        repeat (8) @(posedge rxc);
        tick(4);
        check_v("serial off", 9'h000, serial_in);
        check_v("cell mode", 9'h001, cell_mode);
    endtask

    // Main sequence; reset is released after the eighth core edge
    initial
    begin
        // Idle levels; the clock enable is driven so that freezing is tested
        clk = 1'b0;
        resetn = 1'b0;
        strap = 1'b1;
        ce = 1'b1;
        tx_valid = 1'b0;
        tx_byte = '0;
        tx_whole = 1'b0;
        rx_room = 1'b0;
        repeat (7) @(posedge clk);
        #1;
        t_reset();
        t_tx();
        t_flag();
        t_freeze();
        t_rx();
        t_unsel();
        t_strap();
        end_of_test();
    end
endmodule
